// ### hdl/gps_cfg.svh
// constants for the gpio pin direction and sync block
`ifndef GPS_CFG_SVH
`define GPS_CFG_SVH
// geometry
`define GPS_PORT_W 8
`define GPS_PORT_N 2
`define GPS_PIN_N 16
`define GPS_ADDR_W 8
`define GPS_DATA_W 32
// register indexes (byte address is four times the index)
`define GPS_IDX_INA 6'h00
`define GPS_IDX_DIRA 6'h01
`define GPS_IDX_OUTA 6'h02
`define GPS_IDX_INB 6'h03
`define GPS_IDX_DIRB 6'h04
`define GPS_IDX_OUTB 6'h05
`define GPS_IDX_PCR 6'h12
`define GPS_IDX_MCU 6'h35
// index field of a byte address
`define GPS_IDX_MSB 7
`define GPS_IDX_LSB 2
// field positions and writable masks
`define GPS_MCU_PUD_BIT 4
`define GPS_MCU_MASK 8'h10
`define GPS_PCR_BBM_LSB 4
`define GPS_PCR_PUD_LSB 0
`define GPS_PCR_MASK 8'h33
// reset values
`define GPS_RST_BYTE 8'h00
`define GPS_RST_PINS 16'h0000
// bus responses
`define GPS_RESP_OKAY 2'b00
`define GPS_RESP_SLVERR 2'b10
`endif

// ### hdl/gps_pkg.sv
// types shared by the gpio pin direction and sync block
package gps_pkg;
  // write channel progress, one-hot
  typedef enum logic [1:0] {
    GPS_WR_IDLE = 2'b01,
    GPS_WR_RESP = 2'b10
  } gps_wr_state_type;
endpackage : gps_pkg

// ### hdl/gps_sync_if.sv
// carrier between the port logic and the input synchronizer
`include "gps_cfg.svh"
interface gps_sync_if;
  logic [`GPS_PIN_N-1:0] din;   // clamped pad levels
  logic [`GPS_PIN_N-1:0] level; // synchronized pin input bits
  modport port_side (output din, input level);
  modport sync_side (input din, output level);
endinterface : gps_sync_if

// ### hdl/gps_pin_sync.sv
// two-stage pin input synchronizer: latch then register
`include "gps_cfg.svh"
module gps_pin_sync
  import gps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_sync_b,
  // pad side and pin input bits
  gps_sync_if.sync_side sb
);
  logic [`GPS_PIN_N-1:0] sync_latch; // transparent while mclk high
  logic [`GPS_PIN_N-1:0] pin_input_reg; // pin input bits

  // latch follows the pad while the clock is high, holds when it falls
  always_latch begin
    if (mclk) begin
      sync_latch <= sb.din;
    end
  end

  // held value moves into the pin input bits on the next rising edge
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_input_reg <= `GPS_RST_PINS;
    end else begin
      pin_input_reg <= sync_latch;
    end
  end

  assign sb.level = pin_input_reg;
endmodule : gps_pin_sync

// ### hdl/gps_top.sv
// gpio ports: direction, output value, pull-ups, break-before-make, input sync
`include "gps_cfg.svh"
module gps_top
  import gps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // axi4-lite write address
  input wire logic [`GPS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [`GPS_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`GPS_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [`GPS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pads: port a on bits 7:0, port b on bits 15:8
  input wire logic [`GPS_PIN_N-1:0] pad_in,
  output logic [`GPS_PIN_N-1:0] pad_out,
  output logic [`GPS_PIN_N-1:0] pad_oe,
  output logic [`GPS_PIN_N-1:0] pad_pullup_en,
  // sleep controller and input enable overrides
  input wire logic sleep_active,
  input wire logic [`GPS_PIN_N-1:0] ext_int_en,
  input wire logic [`GPS_PIN_N-1:0] din_ovr_en,
  input wire logic [`GPS_PIN_N-1:0] din_ovr_val,
  // synchronized pin levels and change pulses
  output logic [`GPS_PIN_N-1:0] pin_level,
  output logic [`GPS_PIN_N-1:0] pin_change
);

  // register index of a byte address
  function automatic logic [5:0] reg_index(input logic [`GPS_ADDR_W-1:0] addr);
    reg_index = addr[`GPS_IDX_MSB:`GPS_IDX_LSB];
  endfunction : reg_index

  // port number that owns a pin
  function automatic int pin_port(input int pin);
    pin_port = pin / `GPS_PORT_W;
  endfunction : pin_port

  // reset release synchronizer
  logic rst_meta_reg; // first stage, read only by the second
  logic rst_sync_b; // released copy used by all logic

  // write channel state
  gps_wr_state_type wr_state_reg;
  logic aw_have_reg; // address held
  logic [`GPS_ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg; // data held
  logic [`GPS_DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg;
  logic do_write; // apply held write this cycle
  logic [5:0] wr_idx;
  logic wr_lane; // low byte enabled
  logic [`GPS_PORT_W-1:0] wr_byte;

  // read channel state
  logic rvalid_reg;
  logic [`GPS_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // port registers
  logic [`GPS_PIN_N-1:0] out_reg; // output value bits
  logic [`GPS_PIN_N-1:0] dir_reg; // direction bits
  logic [`GPS_PIN_N-1:0] dir_prev_reg; // direction one cycle ago
  logic [`GPS_PORT_W-1:0] pcr_reg; // port control
  logic [`GPS_PORT_W-1:0] mcu_reg; // mcu control
  logic [`GPS_PIN_N-1:0] level_prev_reg; // previous pin input bits
  logic [`GPS_PIN_N-1:0] change_reg; // change pulses

  // pin side combinational terms
  logic [`GPS_PIN_N-1:0] din_enable; // digital input not clamped
  logic [`GPS_PIN_N-1:0] oe_next;
  logic [`GPS_PIN_N-1:0] pu_next;

  // carrier between the pad logic and the synchronizer
  gps_sync_if sb ();

  // reset: asserts at once, releases through two flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b <= rst_meta_reg;
    end
  end

  // write bookkeeping
  // ready drops while a held item waits, so each channel is taken once per write
  assign do_write = aw_have_reg && w_have_reg && (wr_state_reg == GPS_WR_IDLE);
  assign wr_idx = reg_index(aw_addr_reg);
  assign wr_lane = w_strb_reg[0];
  assign wr_byte = w_data_reg[`GPS_PORT_W-1:0];
  assign s_axi_awready = !aw_have_reg && (wr_state_reg == GPS_WR_IDLE);
  assign s_axi_wready = !w_have_reg && (wr_state_reg == GPS_WR_IDLE);
  assign s_axi_bvalid = (wr_state_reg == GPS_WR_RESP);
  assign s_axi_bresp = bresp_reg;

  // address and data are taken in either order and held
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (do_write) begin
      // both consumed by the write
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
    end else begin
      // capture each channel when offered
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // write response sequencing
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_state_reg <= GPS_WR_IDLE;
      bresp_reg <= `GPS_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        GPS_WR_IDLE: begin
          // apply and answer
          if (do_write) begin
            wr_state_reg <= GPS_WR_RESP;
            unique case (wr_idx)
              `GPS_IDX_INA, `GPS_IDX_DIRA, `GPS_IDX_OUTA,
              `GPS_IDX_INB, `GPS_IDX_DIRB, `GPS_IDX_OUTB,
              `GPS_IDX_PCR, `GPS_IDX_MCU: bresp_reg <= `GPS_RESP_OKAY;
              default: bresp_reg <= `GPS_RESP_SLVERR;
            endcase
          end
        end
        GPS_WR_RESP: begin
          // hold until the master takes it
          if (s_axi_bready) begin
            wr_state_reg <= GPS_WR_IDLE;
          end
        end
      endcase
    end
  end

  // output value bits: plain write, or toggle through pin input
  // a toggle write with a data bit of zero leaves that pin alone
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      out_reg <= `GPS_RST_PINS;
    end else if (do_write && wr_lane) begin
      unique case (wr_idx)
        `GPS_IDX_OUTA: out_reg[`GPS_PORT_W-1:0] <= wr_byte;
        `GPS_IDX_OUTB: out_reg[`GPS_PIN_N-1:`GPS_PORT_W] <= wr_byte;
        // toggle regardless of direction
        `GPS_IDX_INA: out_reg[`GPS_PORT_W-1:0] <= out_reg[`GPS_PORT_W-1:0] ^ wr_byte;
        `GPS_IDX_INB: begin
          out_reg[`GPS_PIN_N-1:`GPS_PORT_W] <= out_reg[`GPS_PIN_N-1:`GPS_PORT_W] ^ wr_byte;
        end
        default: out_reg <= out_reg;
      endcase
    end
  end

  // direction bits
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dir_reg <= `GPS_RST_PINS;
    end else if (do_write && wr_lane) begin
      unique case (wr_idx)
        `GPS_IDX_DIRA: dir_reg[`GPS_PORT_W-1:0] <= wr_byte;
        `GPS_IDX_DIRB: dir_reg[`GPS_PIN_N-1:`GPS_PORT_W] <= wr_byte;
        default: dir_reg <= dir_reg;
      endcase
    end
  end

  // direction history for the break-before-make gap
  // this copy lags one cycle, so a fresh output bit waits for it to catch up
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dir_prev_reg <= `GPS_RST_PINS;
    end else begin
      dir_prev_reg <= dir_reg;
    end
  end

  // control registers; unimplemented bits read zero
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pcr_reg <= `GPS_RST_BYTE;
      mcu_reg <= `GPS_RST_BYTE;
    end else if (do_write && wr_lane) begin
      if (wr_idx == `GPS_IDX_PCR) begin
        pcr_reg <= wr_byte & `GPS_PCR_MASK;
      end
      if (wr_idx == `GPS_IDX_MCU) begin
        mcu_reg <= wr_byte & `GPS_MCU_MASK;
      end
    end
  end

  // read channel: one answer per address, data from flops
  // arready stays low while an answer stands, keeping one read in flight
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= `GPS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= `GPS_RESP_OKAY;
      rdata_reg <= '0;
      unique case (reg_index(s_axi_araddr))
        // pin input bits readable in either direction
        `GPS_IDX_INA: rdata_reg[`GPS_PORT_W-1:0] <= sb.level[`GPS_PORT_W-1:0];
        `GPS_IDX_INB: rdata_reg[`GPS_PORT_W-1:0] <= sb.level[`GPS_PIN_N-1:`GPS_PORT_W];
        `GPS_IDX_DIRA: rdata_reg[`GPS_PORT_W-1:0] <= dir_reg[`GPS_PORT_W-1:0];
        `GPS_IDX_DIRB: rdata_reg[`GPS_PORT_W-1:0] <= dir_reg[`GPS_PIN_N-1:`GPS_PORT_W];
        `GPS_IDX_OUTA: rdata_reg[`GPS_PORT_W-1:0] <= out_reg[`GPS_PORT_W-1:0];
        `GPS_IDX_OUTB: rdata_reg[`GPS_PORT_W-1:0] <= out_reg[`GPS_PIN_N-1:`GPS_PORT_W];
        `GPS_IDX_PCR: rdata_reg[`GPS_PORT_W-1:0] <= pcr_reg;
        `GPS_IDX_MCU: rdata_reg[`GPS_PORT_W-1:0] <= mcu_reg;
        default: rresp_reg <= `GPS_RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // per-pin driver, pull-up and input enable
  // each pin is decoded alone; its port's control bits are picked by pin number
  always_comb begin
    logic pud_eff;
    logic bbm_on;
    pud_eff = 1'b0;
    bbm_on = 1'b0;
    oe_next = '0;
    pu_next = '0;
    din_enable = '0;
    for (int i = 0; i < `GPS_PIN_N; i++) begin
      // effective disable is global or the port's own bit
      pud_eff = mcu_reg[`GPS_MCU_PUD_BIT] | pcr_reg[`GPS_PCR_PUD_LSB + pin_port(i)];
      // break-before-make chosen by the port's bit
      bbm_on = pcr_reg[`GPS_PCR_BBM_LSB + pin_port(i)];
      // with the port's bit set, a fresh input-to-output switch waits one cycle; leaving output is immediate
      oe_next[i] = dir_reg[i] && !(bbm_on && !dir_prev_reg[i]);
      // pull-up only for input with value one, no disable, out of reset
      pu_next[i] = !dir_reg[i] && out_reg[i] && !pud_eff && rst_sync_b;
      // sleep clamps unless external interrupt or alternate override
      if (din_ovr_en[i]) begin
        din_enable[i] = din_ovr_val[i];
      end else begin
        din_enable[i] = !sleep_active || ext_int_en[i];
      end
    end
  end

  // pad drive: tri-state while reset holds the registers clear
  // the gate uses the copy that asserts at once, so pins float with no clock
  assign pad_out = out_reg;
  assign pad_oe = oe_next & {`GPS_PIN_N{rst_sync_b}};
  assign pad_pullup_en = pu_next;

  // clamped level to ground ahead of the synchronizer
  assign sb.din = pad_in & din_enable;

  // two-stage synchronizer
  gps_pin_sync u_gps_pin_sync (
    .mclk(mclk),
    .rst_sync_b(rst_sync_b),
    .sb(sb)
  );

  // change pulses let an interrupt unit see a clamp release
  // a high pin released from the clamp shows here as a one-cycle pulse
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      level_prev_reg <= `GPS_RST_PINS;
      change_reg <= `GPS_RST_PINS;
    end else begin
      level_prev_reg <= sb.level;
      change_reg <= sb.level ^ level_prev_reg;
    end
  end

  assign pin_level = sb.level;
  assign pin_change = change_reg;
endmodule : gps_top

// ### tb/gps_top_assertions.sv
// port checker for the gpio pin block
`include "gps_cfg.svh"
module gps_top_assertions
  import gps_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // pads and input enables
  input wire logic [`GPS_PIN_N-1:0] pad_in,
  input wire logic [`GPS_PIN_N-1:0] pad_out,
  input wire logic [`GPS_PIN_N-1:0] pad_oe,
  input wire logic [`GPS_PIN_N-1:0] pad_pullup_en,
  input wire logic sleep_active,
  input wire logic [`GPS_PIN_N-1:0] ext_int_en,
  input wire logic [`GPS_PIN_N-1:0] din_ovr_en,
  input wire logic [`GPS_PIN_N-1:0] din_ovr_val,
  // synchronized levels
  input wire logic [`GPS_PIN_N-1:0] pin_level,
  input wire logic [`GPS_PIN_N-1:0] pin_change
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_cnt; // edges since reset release, saturating
  logic [`GPS_PIN_N-1:0] held_reg; // clamped pad level as the latch closes
  logic up_ok; // internal reset long gone, history valid
  assign up_ok = up_cnt == 3'h4;
  // skip the edges where the internal reset copy still holds
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) up_cnt <= 3'h0;
    else if (!up_ok) up_cnt <= up_cnt + 3'h1;
  end
  // latch closes at the falling edge; enable picks override, else sleep escape
  always_ff @(negedge mclk) begin
    held_reg <= pad_in & ((din_ovr_en & din_ovr_val) |
      (~din_ovr_en & ({`GPS_PIN_N{~sleep_active}} | ext_int_en)));
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!up_ok);
  a_pull_shape: assert property ((pad_pullup_en & (pad_oe | ~pad_out)) == 16'h0000)
    else $error("pull-up on a driven or low pin");
  a_sync_level: assert property (pin_level == $past(held_reg))
    else $error("pin level not the latched pad level");
  a_change_pulse: assert property (pin_change == ($past(pin_level) ^ $past(pin_level, 2)))
    else $error("change pulse does not follow pin level");
  a_reset_tristate: assert property (disable iff (1'b0) !rst_b |-> pad_oe == 16'h0000)
    else $error("pad driven during reset");
  a_reset_nopull: assert property (disable iff (1'b0) !rst_b |-> pad_pullup_en == 16'h0000)
    else $error("pull-up on during reset");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not withdrawn");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not withdrawn");
  c_bbm_rise: cover property ($rose(pad_oe[0]));
  c_sleep_change: cover property (sleep_active && pin_change != 16'h0000);
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == `GPS_RESP_SLVERR);
endmodule : gps_top_assertions
bind gps_top gps_top_assertions u_gps_top_assertions (
  .mclk(mclk),
  .rst_b(rst_b),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp),
  .pad_in(pad_in),
  .pad_out(pad_out),
  .pad_oe(pad_oe),
  .pad_pullup_en(pad_pullup_en),
  .sleep_active(sleep_active),
  .ext_int_en(ext_int_en),
  .din_ovr_en(din_ovr_en),
  .din_ovr_val(din_ovr_val),
  .pin_level(pin_level),
  .pin_change(pin_change)
);

// ### tb/gps_pad_model.sv
// pad model: the pins and the circuitry wired to them
`include "gps_cfg.svh"
module gps_pad_model
  import gps_pkg::*;
(
  // clock
  input wire logic mclk,
  // device side
  input wire logic [`GPS_PIN_N-1:0] pad_out,
  input wire logic [`GPS_PIN_N-1:0] pad_oe,
  input wire logic [`GPS_PIN_N-1:0] pad_pullup_en,
  // outside driver
  input wire logic [`GPS_PIN_N-1:0] ext_en,
  input wire logic [`GPS_PIN_N-1:0] ext_val,
  // resolved level
  output logic [`GPS_PIN_N-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`GPS_PIN_N-1:0] float_reg = 16'h0000; // undriven pins wander every cycle
  // a floating pin never keeps its last value
  always @(posedge mclk) float_reg <= ~pad_in;
  // device driver first, then the outside source, then pull-up or float
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pad_pullup_en | float_reg));
endmodule : gps_pad_model

// ### tb/gps_pin_direction_sync_test.sv
// self-checking bench for the gpio pin block
`include "gps_cfg.svh"
module gpio_pin_direction_sync_test
  import gps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, sleep_active = 1'b0;
  logic rst_b; // driven low at time zero so reset asserts by an edge
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] pad_in, pad_out, pad_oe, pad_pullup_en, pin_level, pin_change;
  logic [15:0] ext_int_en = 16'h0, din_ovr_en = 16'h0, din_ovr_val = 16'h0;
  logic [15:0] ext_en = 16'h0, ext_val = 16'h0, oe_snap, lvl_snap;
  logic [3:0] sl_tab [6] = '{4'h2, 4'hb, 4'h8, 4'hc, 4'h8, 4'h0}; // sleep, int, ovr en, ovr val
  logic [5:0] sl_exp = 6'b101010; // expected pin level per row
  int err_count = 0, n_compared = 0;
  gps_top u_gps_top (
    .mclk(mclk),
    .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en),
    .sleep_active(sleep_active),
    .ext_int_en(ext_int_en),
    .din_ovr_en(din_ovr_en),
    .din_ovr_val(din_ovr_val),
    .pin_level(pin_level),
    .pin_change(pin_change)
  );
  gps_pad_model u_gps_pad_model (
    .mclk(mclk),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pullup_en(pad_pullup_en),
    .ext_en(ext_en),
    .ext_val(ext_val),
    .pad_in(pad_in)
  );
  always #25 mclk = ~mclk;
  // counts, verdict, stop
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // one comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bus write; pad state snapped at the response edge
  task automatic axi_write(input logic [5:0] idx, input logic [7:0] data, input logic [1:0] resp);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, data};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    oe_snap = pad_oe;
    lvl_snap = pin_level;
    s_axi_bready <= 1'b0;
    check("bresp", resp, s_axi_bresp);
    if (s_axi_bvalid !== 1'b1) begin
      check("bvalid", 32'h1, s_axi_bvalid);
      end_of_test();
    end
  endtask : axi_write
  // bus read into rd
  task automatic axi_read(input logic [5:0] idx, input logic [1:0] resp);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    check("rresp", resp, s_axi_rresp);
    if (s_axi_rvalid !== 1'b1) begin
      check("rvalid", 32'h1, s_axi_rvalid);
      end_of_test();
    end
  endtask : axi_read
  // main sequence
  initial begin
    rst_b <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    axi_read(`GPS_IDX_PCR, `GPS_RESP_OKAY);
    check("pcr_rst", 32'h0, rd);
    axi_read(6'h07, `GPS_RESP_SLVERR);
    axi_write(6'h07, 8'hff, `GPS_RESP_SLVERR);
    $display("test reset and unmapped done");
    // pull-up encoding and both disables
    axi_write(`GPS_IDX_DIRA, 8'h0f, `GPS_RESP_OKAY);
    axi_write(`GPS_IDX_OUTA, 8'h3c, `GPS_RESP_OKAY);
    axi_write(`GPS_IDX_OUTB, 8'h01, `GPS_RESP_OKAY);
    #1 check("oe", 32'h000f, pad_oe);
    check("out", 32'h013c, pad_out);
    check("pull", 32'h0130, pad_pullup_en);
    axi_read(`GPS_IDX_INA, `GPS_RESP_OKAY);
    check("read_back", 32'h3c, rd & 32'h3f);
    axi_write(`GPS_IDX_PCR, 8'h01, `GPS_RESP_OKAY);
    #1 check("pull_port", 32'h0100, pad_pullup_en);
    axi_write(`GPS_IDX_PCR, 8'h02, `GPS_RESP_OKAY);
    #1 check("pull_port_b", 32'h0030, pad_pullup_en);
    axi_write(`GPS_IDX_MCU, 8'h10, `GPS_RESP_OKAY);
    #1 check("pull_glob", 32'h0000, pad_pullup_en);
    axi_write(`GPS_IDX_MCU, 8'h00, `GPS_RESP_OKAY);
    axi_write(`GPS_IDX_INA, 8'h0f, `GPS_RESP_OKAY);
    // a write with its low byte lane off must leave the value bits alone
    s_axi_wstrb <= 4'h0;
    axi_write(`GPS_IDX_OUTA, 8'hff, `GPS_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    axi_read(`GPS_IDX_OUTA, `GPS_RESP_OKAY);
    check("toggle", 32'h33, rd);
    $display("test pin config done");
    // break-before-make per port
    axi_write(`GPS_IDX_PCR, 8'h10, `GPS_RESP_OKAY);
    axi_write(`GPS_IDX_DIRA, 8'h00, `GPS_RESP_OKAY);
    check("oe_off", 32'h0, oe_snap[3:0]);
    axi_write(`GPS_IDX_DIRA, 8'h01, `GPS_RESP_OKAY);
    check("oe_gap", 32'h0, oe_snap[0]);
    #1 check("oe_on", 32'h1, pad_oe[0]);
    axi_write(`GPS_IDX_DIRB, 8'h01, `GPS_RESP_OKAY);
    check("oe_nogap", 32'h1, oe_snap[8]);
    axi_write(`GPS_IDX_PCR, 8'h20, `GPS_RESP_OKAY);
    axi_write(`GPS_IDX_DIRB, 8'h03, `GPS_RESP_OKAY);
    check("oe_gap_b", 32'h0, oe_snap[9]);
    #1 check("oe_on_b", 32'h1, pad_oe[9]);
    $display("test break before make done");
    // written value reaches the pin input one period later
    axi_write(`GPS_IDX_OUTA, 8'h32, `GPS_RESP_OKAY);
    check("lvl_old", 32'h1, lvl_snap[0]);
    #1 check("lvl_new", 32'h0, pin_level[0]);
    // outside driver, then sleep clamp and its escapes on pin 10
    @(posedge mclk);
    ext_en[10] <= 1'b1;
    ext_val[10] <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {sleep_active, ext_int_en[10], din_ovr_en[10], din_ovr_val[10]} <= sl_tab[i];
      @(posedge mclk);
      #1 check("lvl_sleep", sl_exp[i], pin_level[10]);
    end
    @(posedge mclk);
    #1 check("wake_change", 32'h1, pin_change[10]);
    $display("test input sync and sleep done");
    // reset in mid-run drops drive and pull-ups without a clock edge
    @(posedge mclk);
    rst_b <= 1'b0;
    #1 check("oe_reset", 32'h0, pad_oe);
    check("pull_reset", 32'h0, pad_pullup_en);
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    axi_read(`GPS_IDX_DIRA, `GPS_RESP_OKAY);
    check("dir_reset", 32'h0, rd);
    $display("test reset in run done");
    end_of_test();
  end
endmodule : gpio_pin_direction_sync_test
